// *** src/mesl_pkg.sv ***
package mesl_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned NUM_FLAGS = 12;

    // register offsets
    localparam logic [15:0] STATUS_OFS = 16'h0102;
    localparam logic [15:0] ENABLE_OFS = 16'h0104;
    localparam logic [15:0] CONFIG_OFS = 16'h0106;

    // values after reset
    localparam logic [11:0] STATUS_RST = 12'h000;
    localparam logic [11:0] ENABLE_RST = 12'h000;
    localparam logic [7:0]  LIMIT_RST  = 8'h40;
    localparam logic        USER32_RST = 1'b0;

    // config field positions
    localparam int unsigned CFG_USER32_BIT = 0;
    localparam int unsigned CFG_LIMIT_LSB  = 8;

    // status bit positions
    localparam int unsigned BIT_WC_LOSS   = 0;
    localparam int unsigned BIT_RC_LOSS   = 1;
    localparam int unsigned BIT_FS_LOSS   = 2;
    localparam int unsigned BIT_BIP       = 3;
    localparam int unsigned BIT_ACK       = 4;
    localparam int unsigned BIT_NACK      = 5;
    localparam int unsigned BIT_GRANT_TO  = 6;
    localparam int unsigned BIT_SENT      = 7;
    localparam int unsigned BIT_PENDING   = 8;
    localparam int unsigned BIT_RH_CRC    = 9;
    localparam int unsigned BIT_RX_PARITY = 10;
    localparam int unsigned BIT_SOC       = 11;

    // cycle and byte counts
    localparam logic [5:0] CLOCK_LOSS_CYCLES = 6'h20;
    localparam logic [5:0] FS_PERIOD_16      = 6'h10;
    localparam logic [5:0] FS_PERIOD_32      = 6'h20;
    localparam logic [5:0] CELL_BYTES        = 6'h35;

    typedef enum logic {
        RX_IDLE = 1'b0,
        RX_CELL = 1'b1
    } mesl_rx_e;

endpackage

// *** src/mesl_sync3.sv ***
`timescale 1ns/1ps
module mesl_sync3 #(
    parameter int unsigned W = 3
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;
    logic [W-1:0] lvl_d;

    // a change counts once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;
endmodule

// *** src/mesl_top.sv ***
// How it works
// - write clock quiet 32 cycles sets flag
// - read clock quiet 32 cycles sets flag
// - frame sync missing per 16/32 read clocks
// - missing write clock also sets frame-sync flag
// - interleave parity mismatch sets fault flag
// - acknowledged control cell sets flag, not multicast
// - unacknowledged control cell sets flag, not multicast
// - ungranted request past limit sets timeout flag
// - control cell placed on bus sets flag
// - received control cell waiting sets flag
// - routing header check failure sets flag
// - odd parity mismatch on receive sets flag
// - parity fault cells still counted and forwarded
// - start-of-cell framing error sets flag
// - framing-error cells are discarded
// - flag raises interrupt only when enabled
// - interrupt holds until enable or flag clears
`timescale 1ns/1ps
module mesl_top (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        cb_write_clk,
    input  wire logic        cb_read_clk,
    input  wire logic        cb_frame_sync,
    input  wire logic        bip_mismatch,
    input  wire logic        rh_crc_fail,
    input  wire logic        ctrl_tx_done,
    input  wire logic        ctrl_tx_acked,
    input  wire logic        ctrl_tx_multi,
    input  wire logic        ctrl_tx_sent,
    input  wire logic        ctrl_rx_waiting,
    input  wire logic        cb_request,
    input  wire logic        cb_grant,
    input  wire logic        rx_valid,
    input  wire logic        rx_soc,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_parity,
    output logic             rx_cell_accept,
    output logic             rx_cell_drop,
    output logic             irq
);
    logic [2:0]  pin_lvl;
    logic [1:0]  prev_q;
    logic [1:0]  clk_edge, clk_lost;
    logic        rc_rise, fs_miss, grant_to;
    logic [5:0]  loss_cnt_q [2], loss_cnt_d [2];
    logic [5:0]  fs_cnt_q, fs_cnt_d, fs_period;
    logic [7:0]  grant_cnt_q, grant_cnt_d;
    mesl_pkg::mesl_rx_e rx_st_q, rx_st_d;
    logic [5:0]  rx_cnt_q, rx_cnt_d;
    logic        drop_q, drop_d;
    logic        soc_err, par_err, last_byte;
    logic        accept_d, rdrop_d;
    logic [11:0] status_q, status_d;
    logic [11:0] enable_q, enable_d;
    logic        user32_q, user32_d;
    logic [7:0]  limit_q, limit_d;
    logic [11:0] ev, clr;
    logic        irq_d;
    logic [15:0] rdata_d;

    mesl_sync3 #(.W(3)) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .pin_in   ({cb_frame_sync, cb_read_clk, cb_write_clk}),
        .level_out(pin_lvl)
    );

    assign clk_edge = pin_lvl[1:0] ^ prev_q;
    assign rc_rise  = pin_lvl[1] & ~prev_q[1];

    // activity watchdog per link clock, saturating at the loss count
    generate
        for (genvar i = 0; i < 2; i++) begin : g_loss
            always_comb begin
                clk_lost[i] = loss_cnt_q[i] == mesl_pkg::CLOCK_LOSS_CYCLES;
                if (clk_edge[i]) begin
                    loss_cnt_d[i] = 6'h00;
                end else if (clk_lost[i]) begin
                    loss_cnt_d[i] = loss_cnt_q[i];
                end else begin
                    loss_cnt_d[i] = loss_cnt_q[i] + 6'h01;
                end
            end
        end
    endgenerate

    // frame sync window counted in read clock rising edges
    always_comb begin
        fs_period = user32_q ? mesl_pkg::FS_PERIOD_32 : mesl_pkg::FS_PERIOD_16;
        fs_miss   = 1'b0;
        fs_cnt_d  = fs_cnt_q;
        if (rc_rise) begin
            if (pin_lvl[2]) begin
                fs_cnt_d = 6'h00;
            end else if (fs_cnt_q >= fs_period - 6'h01) begin
                fs_miss  = 1'b1;
                fs_cnt_d = 6'h00;
            end else begin
                fs_cnt_d = fs_cnt_q + 6'h01;
            end
        end
    end

    // grant wait counter, stops at the programmed limit
    always_comb begin
        grant_to    = 1'b0;
        grant_cnt_d = grant_cnt_q;
        if (!cb_request || cb_grant) begin
            grant_cnt_d = 8'h00;
        end else if (grant_cnt_q == limit_q) begin
            grant_to = 1'b1;
        end else begin
            grant_cnt_d = grant_cnt_q + 8'h01;
        end
    end

    // receive cell framing and parity
    always_comb begin
        rx_st_d   = rx_st_q;
        rx_cnt_d  = rx_cnt_q;
        drop_d    = drop_q;
        soc_err   = 1'b0;
        accept_d  = 1'b0;
        rdrop_d   = 1'b0;
        par_err   = rx_valid && !(^{rx_data, rx_parity});
        last_byte = rx_cnt_q == mesl_pkg::CELL_BYTES - 6'h01;
        if (rx_valid) begin
            case (rx_st_q)
                mesl_pkg::RX_IDLE: begin
                    if (rx_soc) begin
                        rx_st_d  = mesl_pkg::RX_CELL;
                        rx_cnt_d = 6'h01;
                        drop_d   = 1'b0;
                    end else begin
                        soc_err = 1'b1;
                    end
                end
                mesl_pkg::RX_CELL: begin
                    if (rx_soc) begin
                        soc_err  = 1'b1;
                        drop_d   = 1'b1;
                        rx_cnt_d = 6'h01;
                    end else if (last_byte) begin
                        rx_st_d  = mesl_pkg::RX_IDLE;
                        rx_cnt_d = 6'h00;
                        accept_d = !drop_q;
                        rdrop_d  = drop_q;
                    end else begin
                        rx_cnt_d = rx_cnt_q + 6'h01;
                    end
                end
                default: begin
                    rx_st_d  = mesl_pkg::RX_IDLE;
                    rx_cnt_d = 6'h00;
                end
            endcase
        end
    end

    // event vector and status latch
    always_comb begin
        ev = '0;
        ev[mesl_pkg::BIT_WC_LOSS]   = clk_lost[0];
        ev[mesl_pkg::BIT_RC_LOSS]   = clk_lost[1];
        ev[mesl_pkg::BIT_FS_LOSS]   = fs_miss | clk_lost[0];
        ev[mesl_pkg::BIT_BIP]       = bip_mismatch;
        ev[mesl_pkg::BIT_ACK]       = ctrl_tx_done & ctrl_tx_acked
                                      & ~ctrl_tx_multi;
        ev[mesl_pkg::BIT_NACK]      = ctrl_tx_done & ~ctrl_tx_acked
                                      & ~ctrl_tx_multi;
        ev[mesl_pkg::BIT_GRANT_TO]  = grant_to;
        ev[mesl_pkg::BIT_SENT]      = ctrl_tx_sent;
        ev[mesl_pkg::BIT_PENDING]   = ctrl_rx_waiting;
        ev[mesl_pkg::BIT_RH_CRC]    = rh_crc_fail;
        ev[mesl_pkg::BIT_RX_PARITY] = par_err;
        ev[mesl_pkg::BIT_SOC]       = soc_err;
        clr = (reg_wr && reg_addr == mesl_pkg::STATUS_OFS)
              ? reg_wdata[11:0] : 12'h000;
        status_d = (status_q & ~clr) | ev;
        irq_d    = |(status_q & enable_q);
    end

    // register writes and reads
    always_comb begin
        enable_d = enable_q;
        user32_d = user32_q;
        limit_d  = limit_q;
        if (reg_wr && reg_addr == mesl_pkg::ENABLE_OFS) begin
            enable_d = reg_wdata[11:0];
        end
        if (reg_wr && reg_addr == mesl_pkg::CONFIG_OFS) begin
            user32_d = reg_wdata[mesl_pkg::CFG_USER32_BIT];
            limit_d  = reg_wdata[mesl_pkg::CFG_LIMIT_LSB +: 8];
        end
        rdata_d = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                mesl_pkg::STATUS_OFS: rdata_d = {4'h0, status_q};
                mesl_pkg::ENABLE_OFS: rdata_d = {4'h0, enable_q};
                mesl_pkg::CONFIG_OFS: rdata_d = {limit_q, 7'h00, user32_q};
                default:              rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_q         <= 2'h0;
            loss_cnt_q[0]  <= 6'h00;
            loss_cnt_q[1]  <= 6'h00;
            fs_cnt_q       <= 6'h00;
            grant_cnt_q    <= 8'h00;
            rx_st_q        <= mesl_pkg::RX_IDLE;
            rx_cnt_q       <= 6'h00;
            drop_q         <= 1'b0;
            rx_cell_accept <= 1'b0;
            rx_cell_drop   <= 1'b0;
            status_q       <= mesl_pkg::STATUS_RST;
            enable_q       <= mesl_pkg::ENABLE_RST;
            user32_q       <= mesl_pkg::USER32_RST;
            limit_q        <= mesl_pkg::LIMIT_RST;
            irq            <= 1'b0;
            reg_rdata      <= 16'h0000;
        end else begin
            prev_q         <= pin_lvl[1:0];
            loss_cnt_q[0]  <= loss_cnt_d[0];
            loss_cnt_q[1]  <= loss_cnt_d[1];
            fs_cnt_q       <= fs_cnt_d;
            grant_cnt_q    <= grant_cnt_d;
            rx_st_q        <= rx_st_d;
            rx_cnt_q       <= rx_cnt_d;
            drop_q         <= drop_d;
            rx_cell_accept <= accept_d;
            rx_cell_drop   <= rdrop_d;
            status_q       <= status_d;
            enable_q       <= enable_d;
            user32_q       <= user32_d;
            limit_q        <= limit_d;
            irq            <= irq_d;
            reg_rdata      <= rdata_d;
        end
    end

    // checks
    default clocking d_clk @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_wc_last_quiet;
        loss_cnt_q[0] == 6'h1F && !clk_edge[0];
    endsequence
    property p_wc_loss;
        s_wc_last_quiet |-> ##2 status_q[mesl_pkg::BIT_WC_LOSS]
                                && status_q[mesl_pkg::BIT_FS_LOSS];
    endproperty
    a_wc_loss: assert property (p_wc_loss)
        else $error("write clock loss not flagged");
    property p_rc_loss;
        (loss_cnt_q[1] == 6'h1F && !clk_edge[1])
            |-> ##2 status_q[mesl_pkg::BIT_RC_LOSS];
    endproperty
    a_rc_loss: assert property (p_rc_loss)
        else $error("read clock loss not flagged");
    property p_fs_loss;
        (rc_rise && !pin_lvl[2] && fs_cnt_q == fs_period - 6'h01)
            |=> status_q[mesl_pkg::BIT_FS_LOSS] && fs_cnt_q == 6'h00;
    endproperty
    a_fs_loss: assert property (p_fs_loss)
        else $error("frame sync loss not flagged");
    property p_multi_no_ack;
        (ctrl_tx_done && ctrl_tx_multi && !status_q[mesl_pkg::BIT_ACK]
         && !status_q[mesl_pkg::BIT_NACK])
            |=> !status_q[mesl_pkg::BIT_ACK]
                && !status_q[mesl_pkg::BIT_NACK];
    endproperty
    a_multi_no_ack: assert property (p_multi_no_ack)
        else $error("multicast cell set an acknowledge flag");
    property p_grant_to;
        (cb_request && !cb_grant && grant_cnt_q == limit_q)
            |=> status_q[mesl_pkg::BIT_GRANT_TO];
    endproperty
    a_grant_to: assert property (p_grant_to)
        else $error("grant time-out not flagged");
    property p_parity;
        (rx_valid && ^{rx_data, rx_parity} == 1'b0)
            |=> status_q[mesl_pkg::BIT_RX_PARITY];
    endproperty
    a_parity: assert property (p_parity)
        else $error("receive parity fault not flagged");
    sequence s_soc_mid_cell;
        rx_valid && rx_soc && rx_st_q == mesl_pkg::RX_CELL;
    endsequence
    property p_soc_drop;
        s_soc_mid_cell |=> status_q[mesl_pkg::BIT_SOC] && drop_q
                           && !rx_cell_accept;
    endproperty
    a_soc_drop: assert property (p_soc_drop)
        else $error("framing error did not mark cell for discard");
    property p_irq;
        ((status_q & enable_q) != 12'h000) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled flag did not raise interrupt");
    property p_irq_off;
        ((status_q & enable_q) == 12'h000) |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt without enabled flag");
    property p_w1c;
        (reg_wr && reg_addr == mesl_pkg::STATUS_OFS && reg_wdata[3]
         && !bip_mismatch) |=> !status_q[mesl_pkg::BIT_BIP];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write one did not clear flag");
    property p_set_wins;
        (bip_mismatch && reg_wr && reg_addr == mesl_pkg::STATUS_OFS)
            |=> status_q[mesl_pkg::BIT_BIP];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a new event");
    property p_reserved;
        (reg_rd && reg_addr == mesl_pkg::STATUS_OFS)
            |=> reg_rdata[15:12] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bits not zero");
endmodule

// *** verif/mesl_peer.sv ***
`timescale 1ns/1ps
module mesl_peer (
    input  wire logic       clk,
    input  wire logic       wclk_run,
    input  wire logic       rclk_run,
    input  wire logic       sync_run,
    output logic            cb_write_clk,
    output logic            cb_read_clk,
    output logic            cb_frame_sync,
    output logic            rx_valid,
    output logic            rx_soc,
    output logic [7:0]      rx_data,
    output logic            rx_parity
);
    int rise_n;

    initial begin
        cb_write_clk = 1'b0;
        cb_read_clk = 1'b0;
        cb_frame_sync = 1'b0;
        rx_valid = 1'b0;
        rx_soc = 1'b0;
        rx_data = 8'h00;
        rx_parity = 1'b0;
        rise_n = 15;
    end

    // link clocks freeze while their run input is low
    always begin
        #160;
        if (wclk_run) cb_write_clk = ~cb_write_clk;
    end

    always begin
        #160;
        if (rclk_run) cb_read_clk = ~cb_read_clk;
    end

    // sync held one read clock period in every sixteen, from the first
    always @(negedge cb_read_clk) begin
        rise_n = (rise_n + 1) % 16;
        cb_frame_sync = sync_run && rise_n == 0;
    end

    // odd parity; soc2 marks a stray start, bad spoils byte 7
    task automatic send_cell(input int n, input bit first, input int soc2,
                             input bit bad);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            b = 8'(8'hA5 + i);
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_soc <= (first && i == 0) || i == soc2;
            rx_data <= b;
            rx_parity <= ~^b ^ (bad && i == 7);
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_soc <= 1'b0;
        rx_data <= ~rx_data;
        rx_parity <= ~rx_parity;
    endtask
endmodule

// *** verif/main_event_status_latch_test.sv ***
`timescale 1ns/1ps
module main_event_status_latch_test;
    localparam logic [15:0] ST = mesl_pkg::STATUS_OFS;
    localparam logic [15:0] EN = mesl_pkg::ENABLE_OFS;
    localparam logic [15:0] CF = mesl_pkg::CONFIG_OFS;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [8:0]  ev = 9'h000;
    logic        wrun = 1'b1;
    logic        rrun = 1'b1;
    logic        srun = 1'b1;
    logic [15:0] reg_rdata;
    logic        wclk, rclk, fsync, rxv, rxs, rxp, acc, drop, irq;
    logic [7:0]  rxd;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    int          acc_n = 0;
    int          drop_n = 0;

    always #20 clk = ~clk;

    mesl_peer peer (
        .clk(clk), .wclk_run(wrun), .rclk_run(rrun), .sync_run(srun),
        .cb_write_clk(wclk), .cb_read_clk(rclk), .cb_frame_sync(fsync),
        .rx_valid(rxv), .rx_soc(rxs), .rx_data(rxd), .rx_parity(rxp)
    );

    mesl_top DUT (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cb_write_clk(wclk), .cb_read_clk(rclk),
        .cb_frame_sync(fsync), .bip_mismatch(ev[0]), .rh_crc_fail(ev[1]),
        .ctrl_tx_done(ev[2]), .ctrl_tx_acked(ev[3]),
        .ctrl_tx_multi(ev[4]), .ctrl_tx_sent(ev[5]),
        .ctrl_rx_waiting(ev[6]), .cb_request(ev[7]), .cb_grant(ev[8]),
        .rx_valid(rxv), .rx_soc(rxs), .rx_data(rxd), .rx_parity(rxp),
        .rx_cell_accept(acc), .rx_cell_drop(drop), .irq(irq)
    );

    task automatic complete_run();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (acc === 1'b1) acc_n++;
        if (drop === 1'b1) drop_n++;
        if (cycles == 6000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] e);
        checked++;
        if (got !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    task automatic clr();
        wr(ST, 16'hFFFF);
    endtask

    task automatic setev(input logic [8:0] v);
        @(posedge clk);
        ev <= v;
    endtask

    task automatic irqchk(input logic [15:0] e);
        repeat (3) @(posedge clk);
        #1 chk({15'h0000, irq}, e);
    endtask

    task automatic t_regs();
        rd(ST, 16'h0000);
        rd(EN, 16'h0000);
        rd(CF, 16'h4000);
        rd(16'h0108, 16'h0000);
        wr(EN, 16'hFFFF);
        rd(EN, 16'h0FFF);
        wr(CF, 16'hFFFF);
        rd(CF, 16'hFF01);
        wr(CF, 16'h4000);
        wr(16'h0108, 16'hFFFF);
        clr();
        rd(ST, 16'h0000);
    endtask

    task automatic t_events();
        logic [8:0]  stim [7] = '{9'h001, 9'h002, 9'h020, 9'h00C,
                                  9'h004, 9'h01C, 9'h014};
        logic [15:0] e [7] = '{16'h0008, 16'h0200, 16'h0080, 16'h0010,
                               16'h0020, 16'h0000, 16'h0000};
        for (int i = 0; i < 7; i++) begin
            setev(stim[i]);
            setev(9'h000);
            rd(ST, e[i]);
            wr(ST, 16'h0000);
            rd(ST, e[i]);
            clr();
            rd(ST, 16'h0000);
        end
        fork
            begin
                setev(9'h001);
                setev(9'h000);
            end
            clr();
        join
        rd(ST, 16'h0008);
        clr();
    endtask

    task automatic t_irq();
        wr(EN, 16'h0200);
        setev(9'h001);
        setev(9'h000);
        irqchk(16'h0000);
        wr(EN, 16'h0208);
        setev(9'h002);
        setev(9'h000);
        irqchk(16'h0001);
        wr(ST, 16'h0008);
        irqchk(16'h0001);
        wr(ST, 16'h0200);
        irqchk(16'h0000);
        setev(9'h001);
        setev(9'h000);
        irqchk(16'h0001);
        wr(EN, 16'h0000);
        irqchk(16'h0000);
        clr();
    endtask

    task automatic t_loss();
        @(posedge clk);
        wrun <= 1'b0;
        repeat (60) @(posedge clk);
        rd(ST, 16'h0005);
        wrun <= 1'b1;
        repeat (20) @(posedge clk);
        clr();
        rd(ST, 16'h0000);
        rrun <= 1'b0;
        repeat (60) @(posedge clk);
        rd(ST, 16'h0002);
        rrun <= 1'b1;
        repeat (20) @(posedge clk);
        clr();
        rd(ST, 16'h0000);
    endtask

    task automatic t_sync();
        @(posedge clk);
        srun <= 1'b0;
        clr();
        repeat (170) @(posedge clk);
        rd(ST, 16'h0004);
        wr(CF, 16'h4001);
        clr();
        repeat (110) @(posedge clk);
        rd(ST, 16'h0000);
        repeat (160) @(posedge clk);
        rd(ST, 16'h0004);
        srun <= 1'b1;
        wr(CF, 16'h4000);
        repeat (200) @(posedge clk);
        clr();
        repeat (150) @(posedge clk);
        rd(ST, 16'h0000);
    endtask

    task automatic t_grant();
        wr(CF, 16'h0A00);
        clr();
        setev(9'h080);
        repeat (6) @(posedge clk);
        rd(ST, 16'h0000);
        repeat (8) @(posedge clk);
        rd(ST, 16'h0040);
        setev(9'h180);
        clr();
        repeat (14) @(posedge clk);
        rd(ST, 16'h0000);
        setev(9'h040);
        repeat (3) @(posedge clk);
        clr();
        rd(ST, 16'h0100);
        setev(9'h000);
        clr();
        rd(ST, 16'h0000);
    endtask

    task automatic t_rx();
        peer.send_cell(53, 1'b1, -1, 1'b0);
        repeat (3) @(posedge clk);
        chk(16'(acc_n), 16'h0001);
        rd(ST, 16'h0000);
        peer.send_cell(53, 1'b1, -1, 1'b1);
        repeat (3) @(posedge clk);
        chk(16'(acc_n), 16'h0002);
        rd(ST, 16'h0400);
        clr();
        peer.send_cell(73, 1'b1, 20, 1'b0);
        repeat (3) @(posedge clk);
        chk(16'(acc_n), 16'h0002);
        chk(16'(drop_n), 16'h0001);
        rd(ST, 16'h0800);
        clr();
        peer.send_cell(1, 1'b0, -1, 1'b0);
        rd(ST, 16'h0800);
        clr();
    endtask

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_events();
        t_irq();
        t_loss();
        t_sync();
        t_grant();
        t_rx();
        complete_run();
    end
endmodule
